//--- pkg/rqa_consts.svh
// register map, field positions, reset values and counts of the irq aggregator
// assumes a 32-bit apb slave with byte addresses, one aligned word per register
`ifndef RQA_CONSTS_SVH
`define RQA_CONSTS_SVH

// number of interrupt sources, of them the timer comparators
`define RQA_NUM_SRC 14
`define RQA_NUM_TMR 4
`define RQA_NUM_EVT 10

// byte offsets of the registers
`define RQA_OFS_STATUS 8'h00
`define RQA_OFS_MASK 8'h04
`define RQA_OFS_CTRL 8'h08
`define RQA_OFS_STATE 8'h0C
`define RQA_ADDR_W 8

// source positions inside status and mask
`define RQA_SRC_SEQ 0
`define RQA_SRC_TX 1
`define RQA_SRC_RX 2
`define RQA_SRC_CCA 3
`define RQA_SRC_WTRMRK 4
`define RQA_SRC_FILTER 5
`define RQA_SRC_UNLOCK 6
`define RQA_SRC_WAKE 7
`define RQA_SRC_PBERR 8
`define RQA_SRC_CIPHER 9
`define RQA_SRC_TMR1 10

// control register fields
`define RQA_CTRL_GMASK 0
`define RQA_CTRL_PUSHPULL 1

// state register fields
`define RQA_STATE_REQ 0
`define RQA_STATE_ABORTS 8

// reset values: everything masked, open-drain, nothing pending
`define RQA_RST_MASK 14'h3FFF
`define RQA_RST_GMASK 1'b1
`define RQA_RST_PUSHPULL 1'b0

// cycles from an apb setup phase to pready
`define RQA_APB_WAIT 1
`endif

//--- pkg/rqa_pkg.sv
// types shared by the irq aggregator files
// assumes rqa_consts.svh is on the include path
`include "rqa_consts.svh"

package rqa_pkg;
    // apb request side as one carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`RQA_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } rqa_apb_req_t;

    // apb answer side
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rqa_apb_rsp_t;

    // state of the apb slave
    typedef enum logic [1:0] {
        RQA_IDLE = 2'b00,
        RQA_ACCESS = 2'b01
    } rqa_apb_st_t;
endpackage

//--- hdl/rqa_pend_bit.sv
// one sticky pending bit: set by a source event, cleared by a write of one
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps

module rqa_pend_bit
    import rqa_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_pend
);

    ////////////////////////////////////////////////////////////////////////
    // set beats clear so an event in the acknowledge cycle is kept
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_pend <= 1'b0;
        end else if (i_set) begin
            o_pend <= 1'b1;
        end else if (i_clr) begin
            o_pend <= 1'b0;
        end
    end

    pend_setwin_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_set |=> o_pend) else $error("pending bit lost a set");

endmodule

//--- hdl/rqa_irq_agg.sv
// interrupt aggregator: fourteen sticky sources, masks and one request pin
// assumes sources are one-cycle pulses from logic on i_core_clk, apb on the same clock
//
// Contract
// [R1] fourteen sources: sequence, tx, rx, cca, watermark, filter, unlock, wake, buffer, cipher, timers
// [R2] enabled pending sources are ORed into one active-low request output
// [R3] software selects push-pull or open-drain drive for the request pin
// [R4] every source has its own pending bit readable by the host
// [R5] a pending source reaches the output only while its mask bit is zero
// [R6] a global mask bit blocks any request regardless of other bits
// [R7] pending bits clear only by writing one; writing zero leaves them
// [R8] reading never changes any pending bit
// [R9] request stays asserted while any pending source is unmasked
// [R10] synthesizer unlock aborts the running sequence and sets its pending bit
// [R11] four timer sources come one each from the event timer comparators
// [R12] events latch regardless of mask; reset clears status, masks all, releases pin
`timescale 1ns/1ps
`include "rqa_consts.svh"

module rqa_irq_agg
    import rqa_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire rqa_apb_req_t i_apb,
    output rqa_apb_rsp_t o_apb,
    input wire logic [`RQA_NUM_EVT-1:0] i_evt,
    input wire logic [`RQA_NUM_TMR-1:0] i_tmr_match,
    output logic o_seq_abort,
    output logic o_irq_n_out,
    output logic o_irq_n_oe
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [`RQA_NUM_SRC-1:0] src_evt;
    logic [`RQA_NUM_SRC-1:0] pend;
    logic [`RQA_NUM_SRC-1:0] w1c;
    logic [`RQA_NUM_SRC-1:0] mask_ff;
    logic gmask_ff;
    logic pushpull_ff;
    logic req_ff;
    logic nxt_req;
    logic [7:0] abort_cnt_ff;
    rqa_apb_st_t apb_st_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic pslverr_ff;
    logic wr_fire;
    logic setup;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////
    // address decode, used for both the read mux and the write strobes
    function automatic logic reg_hit(input logic [`RQA_ADDR_W-1:0] addr,
                                     input logic [`RQA_ADDR_W-1:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // source vector
    // [R1] fourteen sources
    // [R11] timers from comparators
    assign src_evt = {i_tmr_match, i_evt};

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: no wait state, pready in the first access cycle; read data comes from a register
    assign setup = i_apb.psel && !i_apb.penable;
    assign mapped = reg_hit(i_apb.paddr, `RQA_OFS_STATUS) ||
                    reg_hit(i_apb.paddr, `RQA_OFS_MASK) ||
                    reg_hit(i_apb.paddr, `RQA_OFS_CTRL) ||
                    reg_hit(i_apb.paddr, `RQA_OFS_STATE);
    // a write lands only at the edge where the master sees pready
    assign wr_fire = i_apb.psel && i_apb.penable && pready_ff && i_apb.pwrite
                     && !pslverr_ff;

    // slave state machine
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            apb_st_ff <= RQA_IDLE;
        end else begin
            case (apb_st_ff)
                RQA_IDLE: begin
                    if (setup) begin
                        apb_st_ff <= RQA_ACCESS;
                    end
                end
                RQA_ACCESS: begin
                    apb_st_ff <= RQA_IDLE;
                end
                default: begin
                    apb_st_ff <= RQA_IDLE;
                end
            endcase
        end
    end

    // pready and pslverr for exactly the access cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup && (apb_st_ff == RQA_IDLE);
            pslverr_ff <= setup && (apb_st_ff == RQA_IDLE) && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the setup cycle
    // [R4] pending bits readable
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (reg_hit(i_apb.paddr, `RQA_OFS_STATUS)) begin
            nxt_prdata[`RQA_NUM_SRC-1:0] = pend;
        end else if (reg_hit(i_apb.paddr, `RQA_OFS_MASK)) begin
            nxt_prdata[`RQA_NUM_SRC-1:0] = mask_ff;
        end else if (reg_hit(i_apb.paddr, `RQA_OFS_CTRL)) begin
            nxt_prdata[`RQA_CTRL_GMASK] = gmask_ff;
            nxt_prdata[`RQA_CTRL_PUSHPULL] = pushpull_ff;
        end else if (reg_hit(i_apb.paddr, `RQA_OFS_STATE)) begin
            nxt_prdata[`RQA_STATE_REQ] = req_ff;
            nxt_prdata[`RQA_STATE_ABORTS +: 8] = abort_cnt_ff;
        end
    end

    // read data register; holds between transfers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !i_apb.pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign o_apb.pready = pready_ff;
    assign o_apb.pslverr = pslverr_ff;
    assign o_apb.prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // pending bits; reads take no part in clearing
    // [R7] write one clears
    // [R8] reads leave status
    assign w1c = (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_STATUS)) ?
                 i_apb.pwdata[`RQA_NUM_SRC-1:0] : '0;

    // [R12] latch regardless of mask
    genvar gi;
    generate
        for (gi = 0; gi < `RQA_NUM_SRC; gi++) begin : g_pend
            rqa_pend_bit u_pend (
                .i_core_clk(i_core_clk),
                .i_reset(i_reset),
                .i_set(src_evt[gi]),
                .i_clr(w1c[gi]),
                .o_pend(pend[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // mask and control registers, all masked after reset
    // [R12] reset masks everything
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mask_ff <= `RQA_RST_MASK;
        end else if (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_MASK)) begin
            mask_ff <= i_apb.pwdata[`RQA_NUM_SRC-1:0];
        end
    end

    // [R3] drive mode select
    // [R6] global mask bit
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            gmask_ff <= `RQA_RST_GMASK;
            pushpull_ff <= `RQA_RST_PUSHPULL;
        end else if (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_CTRL)) begin
            gmask_ff <= i_apb.pwdata[`RQA_CTRL_GMASK];
            pushpull_ff <= i_apb.pwdata[`RQA_CTRL_PUSHPULL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request combine; pin lags pending by one cycle, registered from nxt_req beside req_ff
    // [R2] or of enabled sources
    // [R5] mask zero enables
    // [R9] held while any unmasked
    assign nxt_req = !gmask_ff && |(pend & ~mask_ff);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // pin drive; open-drain only pulls low, an external pull-up sets high
    // [R3] push-pull or open-drain
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_irq_n_out <= 1'b1;
            o_irq_n_oe <= 1'b0;
        end else if (pushpull_ff) begin
            o_irq_n_out <= !nxt_req;
            o_irq_n_oe <= 1'b1;
        end else begin
            o_irq_n_out <= 1'b0;
            o_irq_n_oe <= nxt_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synthesizer unlock aborts the sequence; counter saturates for software
    // [R10] unlock aborts sequence
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_seq_abort <= 1'b0;
        end else begin
            o_seq_abort <= i_evt[`RQA_SRC_UNLOCK];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            abort_cnt_ff <= 8'h00;
        end else if (i_evt[`RQA_SRC_UNLOCK] && abort_cnt_ff != 8'hFF) begin
            abort_cnt_ff <= abort_cnt_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // event latches even when masked
    evt_latch_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R12]
        src_evt[`RQA_SRC_TMR1] |=> pend[`RQA_SRC_TMR1])
        else $error("timer one event not latched");

    // pin asserted in the cycle after an unmasked pending source
    req_drive_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
        (!gmask_ff && |(pend & ~mask_ff)) |=> (o_irq_n_oe && !o_irq_n_out))
        else $error("request not driven low");

    // masked sources stay silent
    mask_block_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
        ((pend & ~mask_ff) == '0) |=> !req_ff)
        else $error("masked source reached request");

    // global mask wins
    gmask_block_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R6]
        gmask_ff |=> !req_ff)
        else $error("global mask did not block");

    // a zero write keeps a pending bit
    w0_keep_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R7]
        (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_STATUS) && pend[0] && !i_apb.pwdata[0])
        |=> pend[0])
        else $error("zero write cleared status");

    // a one write clears when no new event
    w1_clear_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R7]
        (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_STATUS) && i_apb.pwdata[1] && !src_evt[1])
        |=> !pend[1])
        else $error("one write did not clear");

    // reads do not disturb status
    read_keep_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R8]
        (i_apb.psel && !i_apb.pwrite && src_evt == '0) |=> $stable(pend))
        else $error("read changed status");

    // request stays while cause stays
    req_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R9]
        (req_ff && nxt_req) |=> req_ff [*1] ##1 (req_ff || !$past(nxt_req)))
        else $error("request dropped early");

    // open-drain never drives high
    od_mode_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R3]
        (!pushpull_ff && !$past(pushpull_ff)) |-> !(o_irq_n_oe && o_irq_n_out))
        else $error("open drain drove high");

    // unlock gives abort and pending one cycle later
    unlock_abort_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R10]
        i_evt[`RQA_SRC_UNLOCK] |=> (o_seq_abort && pend[`RQA_SRC_UNLOCK]))
        else $error("unlock did not abort");

    // reset leaves pin released
    rst_release_a: assert property (@(posedge i_core_clk) // [R12]
        ($past(i_reset) && !i_reset) |->
        (!o_irq_n_oe && pend == '0 && mask_ff == `RQA_RST_MASK))
        else $error("reset state wrong");

    // pready one cycle after setup
    apb_wait_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (setup && apb_st_ff == RQA_IDLE) |=> pready_ff ##1 !pready_ff)
        else $error("pready timing wrong");

    // unmapped address answers with an error beside pready
    err_unmapped_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (setup && apb_st_ff == RQA_IDLE && !mapped) |=> (pready_ff && pslverr_ff))
        else $error("unmapped access without error");

    // an errored write leaves mask and control alone
    err_nowrite_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (i_apb.psel && i_apb.penable && pslverr_ff) |=>
        ($stable(mask_ff) && $stable(gmask_ff) && $stable(pushpull_ff)))
        else $error("errored write changed a register");

    // a status read returns the pending bits of its setup cycle
    status_view_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R4]
        (setup && !i_apb.pwrite && reg_hit(i_apb.paddr, `RQA_OFS_STATUS)) |=>
        (prdata_ff[`RQA_NUM_SRC-1:0] == $past(pend)))
        else $error("status read wrong");

    // bits above the widest register always read zero
    rsvd_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R4]
        pready_ff |-> (prdata_ff[31:16] == 16'h0000))
        else $error("reserved read bits set");

    // a mask write lands whole at the access edge
    mask_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
        (wr_fire && reg_hit(i_apb.paddr, `RQA_OFS_MASK)) |=>
        (mask_ff == $past(i_apb.pwdata[`RQA_NUM_SRC-1:0])))
        else $error("mask write lost");

    // push-pull drives the idle level high itself
    pp_idle_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R3]
        (pushpull_ff && !nxt_req) |=> (o_irq_n_oe && o_irq_n_out))
        else $error("push-pull idle not driven high");

    // open-drain lets go of the pin when nothing is asked
    od_release_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R3]
        (!pushpull_ff && !nxt_req) |=> !o_irq_n_oe)
        else $error("open drain held the pin");

    // abort only follows an unlock, never by itself
    abort_cause_a: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R10]
        o_seq_abort |-> $past(i_evt[`RQA_SRC_UNLOCK]))
        else $error("abort without unlock");

    // covers
    req_seen_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        !o_irq_n_out && o_irq_n_oe);
    ack_seen_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        req_ff ##1 !req_ff);
    setclr_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        |(src_evt & w1c));
    unlock_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        o_seq_abort);
    pp_req_c: cover property (@(posedge i_core_clk) disable iff (i_reset)
        pushpull_ff && req_ff);

endmodule

//--- bench/rqa_host_model.sv
// host side of the active-low request pin: pull-up resolution, request count
// assumes i_irq_n_oe high means the device drives the pin
`timescale 1ns/1ps

module rqa_host_model (
    input wire logic i_core_clk,
    input wire logic i_irq_n_out,
    input wire logic i_irq_n_oe,
    output logic o_irq_line,
    output logic [15:0] o_req_edges
);
    logic line_ff = 1'b1;
    logic [15:0] edges_ff = 16'h0000;
    // a released pin goes to the board pull-up, never the last driven level
    assign o_irq_line = i_irq_n_oe ? i_irq_n_out : 1'b1;
    // host input counts falling edges as new requests
    always @(posedge i_core_clk) begin
        line_ff <= o_irq_line;
        if (line_ff && !o_irq_line) begin
            edges_ff <= edges_ff + 16'h0001;
        end
    end
    assign o_req_edges = edges_ff;
endmodule

//--- bench/rqa_irq_agg_tb.sv
// self-checking bench of the irq aggregator: apb driver, event pulser, pin checks
// assumes the design answers apb in one access cycle and the pin has a pull-up
`timescale 1ns/1ps
`include "rqa_consts.svh"

module rqa_irq_agg_tb;
    import rqa_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    rqa_apb_req_t apb_req = '0;
    rqa_apb_rsp_t apb_rsp;
    logic [9:0] evt = '0;
    logic [3:0] tmr = '0;
    logic seq_abort, irq_out, irq_oe, irq_line;
    logic [15:0] req_edges;
    int bad_count = 0;
    int total_checks = 0;
    logic [33:0] exp_q[$];
    logic [13:0] m_pend = '0;
    logic [13:0] m_mask = `RQA_RST_MASK;
    logic m_gmask = 1'b1;
    logic m_pp = 1'b0;
    logic [7:0] m_aborts = '0;
    logic [13:0] p;

    always #4 i_core_clk = ~i_core_clk;

    rqa_irq_agg rqa_irq_agg_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_apb(apb_req), .o_apb(apb_rsp), .i_evt(evt), .i_tmr_match(tmr),
        .o_seq_abort(seq_abort), .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe));
    rqa_host_model rqa_host_model_inst (.i_core_clk(i_core_clk), .i_irq_n_out(irq_out),
        .i_irq_n_oe(irq_oe), .o_irq_line(irq_line), .o_req_edges(req_edges));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // monitor: every answer takes the oldest note; write data is not compared
    always @(posedge i_core_clk) begin
        logic [33:0] e;
        if (!i_reset && apb_rsp.pready === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            chk_rd({apb_rsp.pslverr, e[33] ? apb_rsp.prdata : 32'h0000_0000}, e[32:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one apb transfer; holds the request until pready, bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int n;
        exp_q.push_back({~wr, exp});
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_core_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        apb_req <= '0;
        @(posedge i_core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {1'b0, 32'h0000_0000});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0000_0000, {1'b0, d});
    endtask

    function automatic logic req();
        return (|(m_pend & ~m_mask)) & ~m_gmask;
    endfunction

    // pin settles two edges after the cause; compared mid-cycle
    task automatic pin_chk();
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk_pin({irq_oe, irq_line}, {m_pp | req(), ~req()});
        @(posedge i_core_clk);
    endtask

    task automatic st_chk();
        rd(`RQA_OFS_STATUS, {18'h0_0000, m_pend});
        rd(`RQA_OFS_STATE, {16'h0000, m_aborts, 7'h00, req()});
    endtask

    // one-cycle source pulse; unlock must give a one-cycle abort next cycle
    task automatic pulse(input logic [13:0] v);
        evt <= v[9:0];
        tmr <= v[13:10];
        @(posedge i_core_clk);
        evt <= '0;
        tmr <= '0;
        m_pend |= v;
        m_aborts += (v[6] && m_aborts != 8'hff) ? 8'h01 : 8'h00;
        @(negedge i_core_clk);
        chk_pin({1'b0, seq_abort}, {1'b0, v[6]});
        @(posedge i_core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0000_2caa));
        for (int r = 0; r < 2; r++) begin
            repeat (2) @(posedge i_core_clk);
            i_reset <= 1'b0;
            @(posedge i_core_clk);
            m_pend = '0;
            m_mask = `RQA_RST_MASK;
            m_gmask = 1'b1;
            m_pp = 1'b0;
            m_aborts = '0;
            rd(`RQA_OFS_MASK, {18'h0_0000, `RQA_RST_MASK});
            rd(`RQA_OFS_CTRL, 32'h0000_0001);
            st_chk();
            pin_chk();
            apb(1'b1, 8'h10, 32'hffff_ffff, {1'b1, 32'h0000_0000});
            apb(1'b0, 8'h14, 32'h0000_0000, {1'b1, 32'h0000_0000});
            $display("test reset %0d done", r);
            // every source latches while masked, one at a time
            for (int i = 0; i < 14; i++) begin
                pulse(14'h0001 << i);
            end
            st_chk();
            st_chk();
            pin_chk();
            wr(`RQA_OFS_CTRL, 32'h0000_0000);
            m_gmask = 1'b0;
            pin_chk();
            wr(`RQA_OFS_MASK, 32'h0000_0000);
            m_mask = '0;
            pin_chk();
            wr(`RQA_OFS_CTRL, 32'h0000_0001);
            m_gmask = 1'b1;
            pin_chk();
            wr(`RQA_OFS_CTRL, 32'h0000_0000);
            m_gmask = 1'b0;
            // host acknowledges by writing one; zero leaves bits alone
            wr(`RQA_OFS_STATUS, 32'h0000_0000);
            st_chk();
            for (int i = 0; i < 14; i++) begin
                wr(`RQA_OFS_STATUS, 32'h0000_0001 << i);
                m_pend[i] = 1'b0;
                pin_chk();
            end
            st_chk();
            $display("test ack done");
            // random masks against random sources, both drive modes
            for (int k = 0; k < 6; k++) begin
                if (k == 3) begin
                    wr(`RQA_OFS_CTRL, 32'h0000_0002);
                    m_pp = 1'b1;
                end
                p = 14'($urandom);
                m_mask = 14'($urandom);
                wr(`RQA_OFS_MASK, {18'h0_0000, m_mask});
                rd(`RQA_OFS_MASK, {18'h0_0000, m_mask});
                pulse(p);
                pin_chk();
                st_chk();
                wr(`RQA_OFS_STATUS, {18'h0_0000, p});
                m_pend &= ~p;
                pin_chk();
            end
            $display("test masks done edges %0d", req_edges);
            // second pass starts with a reset in mid-run
            i_reset <= 1'b1;
        end
        end_sim();
    end
endmodule
